//--- logic/srp_map.svh
// constants of the two-wire register port: addresses, map and timing
`ifndef SRP_MAP_SVH
`define SRP_MAP_SVH

// ****************************************************************
// slave address and register map
// ****************************************************************
`define SRP_FIXED_ADDR 5'h13
`define SRP_NUM_REGS 30
`define SRP_REG_TOP 8'h1d
`define SRP_REG_TEST_B 5'h1b
`define SRP_REG_FMT 5'h1c
`define SRP_FMT_422_BIT 1
`define SRP_REG_RESET 8'h00
`define SRP_TEST_B_VALUE 8'h10
`define SRP_FMT_TEST_VALUE 8'h6f

// ****************************************************************
// timing
// ****************************************************************
`define SRP_CLK_NS 100
`define SRP_SCL_PERIOD_NS 800
`define SRP_QTR_CYC (`SRP_SCL_PERIOD_NS / (4 * `SRP_CLK_NS))

`endif

//--- logic/srp_pkg.sv
// types shared by both ends of the two-wire register port
package srp_pkg;
  `include "srp_map.svh"

  // ****************************************************************
  // device end
  // ****************************************************************
  typedef enum logic [2:0] {DV_IDLE, DV_RX, DV_ACK, DV_TX, DV_TACK} srp_dev_st_type;
  typedef enum logic [1:0] {SG_ADDR, SG_INDEX, SG_DATA} srp_stage_type;

  typedef struct packed {
    srp_dev_st_type st;
    srp_stage_type stage;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic mack;
    logic oe;
    logic scl_q;
    logic sda_q;
    logic [`SRP_NUM_REGS-1:0][7:0] regs;
    logic phase;
    logic [7:0] out_r;
    logic [7:0] out_g;
    logic [7:0] out_b;
    logic out_b_oe;
  } srp_dev_state_type;

  // ****************************************************************
  // master end
  // ****************************************************************
  typedef enum logic [3:0] {
    H_IDLE, H_START, H_ADDR, H_IDX, H_WR, H_RSTART, H_RADDR, H_RD, H_STOP
  } srp_host_st_type;

  typedef struct packed {
    srp_host_st_type st;
    logic [1:0] ph;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [1:0] n_byte;
    logic [1:0] count;
    logic rd;
    logic [6:0] dev;
    logic [7:0] index;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic scl_oe;
    logic sda_oe;
    logic busy;
    logic done;
    logic nack;
  } srp_host_state_type;
endpackage

//--- logic/srp_if.sv
// two-wire link between master end and device end, with pull-ups
`timescale 1ns/1ps
interface srp_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // open drain: a line reads low only while some party drives a low
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface

//--- logic/srp_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module srp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // pins in, synchronised levels out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } srp_sync_state_type;

  srp_sync_state_type s;
  srp_sync_state_type n;

  // first stage feeds only the second stage
  always_comb begin
    n = s;
    n.s1 = async_i;
    n.s2 = s.s1;
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s <= {INIT, INIT};
    end else begin
      s <= n;
    end
  end

  assign sync_o = s.s2;
endmodule

//--- logic/srp_dev.sv
// device end: two-wire slave with register file and output formatter
// What this block does
// - answers only its own address among four
// - slave only, never starts a transfer
// - changes SDA only while SCL is low
// - SDA edge with SCL high: start/stop
// - master starts by SDA falling, SCL high
// - first byte: seven address bits, direction
// - acks own address on ninth pulse
// - address 10011 plus two select pins
// - every byte shifted MSB first
// - write refusal leaves SDA released high
// - master nack ends read, SDA released
// - second write byte is register index
// - pointer advances after each written byte
// - pointer saturates at top register 1Dh
// - no ack for index above 1Dh
// - read starts at stored index, advances
// - master ends every transfer with stop
// - repeated start accepted, new address byte
// - 1Ch bit selects 4:2:2, blue floats
// - software writes 10h into 1Bh
// - software writes 6Fh into 1Ch upper
`timescale 1ns/1ps
`include "srp_map.svh"
module srp_dev
  import srp_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // two-wire link
  srp_if.dev bus,
  // address straps
  input wire logic [1:0] addr_select_pins_i,
  // pixel input
  input wire logic pix_valid_i,
  input wire logic [7:0] pix_r_i,
  input wire logic [7:0] pix_g_i,
  input wire logic [7:0] pix_b_i,
  // pixel output
  output logic [7:0] out_r_o,
  output logic [7:0] out_g_o,
  output logic [7:0] out_b_o,
  output logic out_b_oe_o,
  // configuration seen by the rest of the chip
  output logic fmt_422_o,
  output logic [7:0] test_b_o,
  output logic [7:0] fmt_test_o
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic [1:0] sel_s;

  srp_sync #(
    .W(4),
    .INIT(4'hf)
  ) u_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i({bus.scl, bus.sda, addr_select_pins_i}),
    .sync_o(pins_s)
  );

  assign scl_s = pins_s[3];
  assign sda_s = pins_s[2];
  assign sel_s = pins_s[1:0];

  // ****************************************************************
  // state
  // ****************************************************************
  srp_dev_state_type s;
  srp_dev_state_type n;
  logic [7:0] rd_byte;
  logic fmt_422;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;

  // bus conditions, all taken from the second synchroniser stage
  assign start_seen = scl_s && s.scl_q && s.sda_q && !sda_s;
  assign stop_seen = scl_s && s.scl_q && !s.sda_q && sda_s;
  assign scl_rise = scl_s && !s.scl_q;
  assign scl_fall = !scl_s && s.scl_q;
  assign rd_byte = s.regs[s.ptr[4:0]];
  assign fmt_422 = s.regs[`SRP_REG_FMT][`SRP_FMT_422_BIT];

  // ****************************************************************
  // slave sequencer and formatter
  // ****************************************************************
  always_comb begin
    n = s;
    n.scl_q = scl_s;
    n.sda_q = sda_s;
    if (start_seen) begin
      // a start in any state, repeated or not, opens a new address byte
      n.st = DV_RX;
      n.stage = SG_ADDR;
      n.cnt = 4'h0;
      n.oe = 1'b0;
    end else if (stop_seen) begin
      n.st = DV_IDLE;
      n.oe = 1'b0;
    end else if (scl_rise) begin
      // sample on the rising edge; SDA is stable while SCL is high
      unique case (s.st)
        DV_IDLE: ;
        DV_RX: begin
          n.sh = {s.sh[6:0], sda_s};
          n.cnt = s.cnt + 4'h1;
        end
        DV_ACK: ;
        DV_TX: n.cnt = s.cnt + 4'h1;
        DV_TACK: n.mack = !sda_s;
      endcase
    end else if (scl_fall) begin
      // every change of our drive happens just after SCL falls
      unique case (s.st)
        DV_IDLE: ;
        DV_RX: begin
          if (s.cnt == 4'h8) begin
            n.st = DV_ACK;
            n.oe = 1'b1;
            n.cnt = 4'h0;
            unique case (s.stage)
              SG_ADDR: begin
                if (s.sh[7:1] == {`SRP_FIXED_ADDR, sel_s}) begin
                  n.rw = s.sh[0];
                end else begin
                  n.st = DV_IDLE;
                  n.oe = 1'b0;
                end
              end
              SG_INDEX: begin
                if (s.sh <= `SRP_REG_TOP) begin
                  n.ptr = s.sh;
                end else begin
                  n.st = DV_IDLE;
                  n.oe = 1'b0;
                end
              end
              SG_DATA: begin
                n.regs[s.ptr[4:0]] = s.sh;
                if (s.ptr != `SRP_REG_TOP) begin
                  n.ptr = s.ptr + 8'h01;
                end
              end
              default: begin
                n.st = DV_IDLE;
                n.oe = 1'b0;
              end
            endcase
          end
        end
        DV_ACK: begin
          n.oe = 1'b0;
          if (s.stage == SG_ADDR && s.rw) begin
            // read: first byte comes from the stored index
            n.st = DV_TX;
            n.sh = rd_byte;
            n.oe = !rd_byte[7];
          end else begin
            n.st = DV_RX;
            n.stage = (s.stage == SG_ADDR) ? SG_INDEX : SG_DATA;
          end
        end
        DV_TX: begin
          if (s.cnt == 4'h8) begin
            n.oe = 1'b0;
            n.st = DV_TACK;
            if (s.ptr != `SRP_REG_TOP) begin
              n.ptr = s.ptr + 8'h01;
            end
          end else begin
            n.sh = {s.sh[6:0], 1'b0};
            n.oe = !s.sh[6];
          end
        end
        DV_TACK: begin
          if (s.mack) begin
            n.st = DV_TX;
            n.cnt = 4'h0;
            n.sh = rd_byte;
            n.oe = !rd_byte[7];
          end else begin
            n.st = DV_IDLE;
          end
        end
      endcase
    end

    // blue pins float whenever 4:2:2 is selected, not only per pixel
    n.out_b_oe = !fmt_422;
    if (pix_valid_i) begin
      n.out_g = pix_g_i;
      if (fmt_422) begin
        // red carries U and V on alternate pixels, starting with U
        n.out_r = s.phase ? pix_r_i : pix_b_i;
        n.out_b = 8'h00;
        n.phase = !s.phase;
      end else begin
        n.out_r = pix_r_i;
        n.out_b = pix_b_i;
        n.phase = 1'b0;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.regs <= {`SRP_NUM_REGS{`SRP_REG_RESET}};
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.out_b_oe <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // open drain: we only ever pull low, never drive high
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = s.oe;
  assign out_r_o = s.out_r;
  assign out_g_o = s.out_g;
  assign out_b_o = s.out_b;
  assign out_b_oe_o = s.out_b_oe;
  assign fmt_422_o = fmt_422;
  assign test_b_o = s.regs[`SRP_REG_TEST_B];
  assign fmt_test_o = s.regs[`SRP_REG_FMT];
endmodule

//--- logic/srp_host.sv
// master end: runs one write or indexed read of up to four bytes
`timescale 1ns/1ps
`include "srp_map.svh"
module srp_host
  import srp_pkg::*;
#(
  parameter int QTR_CYC = `SRP_QTR_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // two-wire link
  srp_if.host bus,
  // command
  input wire logic cmd_valid_i,
  input wire logic cmd_read_i,
  input wire logic [6:0] cmd_dev_addr_i,
  input wire logic [7:0] cmd_index_i,
  input wire logic [1:0] cmd_count_i,
  input wire logic [31:0] cmd_wdata_i,
  // answer
  output logic busy_o,
  output logic done_o,
  output logic nack_o,
  output logic [31:0] rdata_o
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic sda_s;
  srp_host_state_type s;
  srp_host_state_type n;

  srp_sync #(
    .W(1),
    .INIT(1'h1)
  ) u_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i(bus.sda),
    .sync_o(sda_s)
  );

  // ****************************************************************
  // symbol sequencer: each symbol is four quarter-period phases
  // ****************************************************************
  always_comb begin
    logic tick;
    logic scl_lvl;
    logic sda_lvl;
    logic [1:0] nb1;
    tick = (s.div == 8'(QTR_CYC - 1));
    scl_lvl = 1'b1;
    sda_lvl = 1'b1;
    nb1 = s.n_byte + 2'h1;
    n = s;
    n.done = 1'b0;
    n.div = tick ? 8'h00 : s.div + 8'h01;
    if (s.st == H_IDLE) begin
      if (cmd_valid_i) begin
        n.st = H_START;
        n.ph = 2'h0;
        n.div = 8'h00;
        n.busy = 1'b1;
        n.nack = 1'b0;
        n.rd = cmd_read_i;
        n.dev = cmd_dev_addr_i;
        n.index = cmd_index_i;
        n.count = cmd_count_i;
        n.wdata = cmd_wdata_i;
      end
    end else if (tick) begin
      unique case (s.st)
        H_START, H_RSTART: begin
          // SDA falls in the middle of the SCL high time
          scl_lvl = (s.ph == 2'h1) || (s.ph == 2'h2);
          sda_lvl = (s.ph < 2'h2);
        end
        H_STOP: begin
          scl_lvl = (s.ph != 2'h0);
          sda_lvl = (s.ph >= 2'h2);
        end
        H_RD: begin
          // ack all bytes but the last, which is refused
          scl_lvl = (s.ph == 2'h1) || (s.ph == 2'h2);
          sda_lvl = (s.bitn != 4'h8) || (s.n_byte == s.count);
        end
        default: begin
          // data held over the whole symbol: stable while SCL high
          scl_lvl = (s.ph == 2'h1) || (s.ph == 2'h2);
          sda_lvl = (s.bitn != 4'h8) ? s.sh[7] : 1'b1;
        end
      endcase
      n.scl_oe = !scl_lvl;
      n.sda_oe = !sda_lvl;
      n.ph = s.ph + 2'h1;
      if (s.ph == 2'h3) begin
        n.bitn = s.bitn + 4'h1;
        unique case (s.st)
          H_IDLE: ;
          H_START: begin
            n.st = H_ADDR;
            n.sh = {s.dev, 1'b0};
            n.bitn = 4'h0;
          end
          H_RSTART: begin
            n.st = H_RADDR;
            n.sh = {s.dev, 1'b1};
            n.bitn = 4'h0;
          end
          H_STOP: begin
            n.st = H_IDLE;
            n.busy = 1'b0;
            n.done = 1'b1;
          end
          H_RD: begin
            if (s.bitn != 4'h8) begin
              n.sh = {s.sh[6:0], sda_s};
            end else begin
              n.bitn = 4'h0;
              n.rdata[8*s.n_byte +: 8] = s.sh;
              if (s.n_byte == s.count) begin
                n.st = H_STOP;
              end else begin
                n.n_byte = nb1;
              end
            end
          end
          default: begin
            if (s.bitn != 4'h8) begin
              n.sh = {s.sh[6:0], 1'b0};
            end else if (sda_s) begin
              n.bitn = 4'h0;
              n.nack = 1'b1;
              n.st = H_STOP;
            end else begin
              n.bitn = 4'h0;
              n.n_byte = 2'h0;
              if (s.st == H_ADDR) begin
                n.st = H_IDX;
                n.sh = s.index;
              end else if (s.st == H_IDX) begin
                n.st = s.rd ? H_RSTART : H_WR;
                n.sh = s.wdata[7:0];
              end else if (s.st == H_RADDR) begin
                n.st = H_RD;
              end else if (s.n_byte == s.count) begin
                n.st = H_STOP;
              end else begin
                n.n_byte = nb1;
                n.sh = s.wdata[8*nb1 +: 8];
              end
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = s.scl_oe;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = s.sda_oe;
  assign busy_o = s.busy;
  assign done_o = s.done;
  assign nack_o = s.nack;
  assign rdata_o = s.rdata;
endmodule

//--- tb/srp_link_properties.sv
// link checker for the two-wire register port
`timescale 1ns/1ps
`include "srp_map.svh"
module srp_link_properties (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // link levels, device enable and straps
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic [1:0] addr_select_pins_i
);
  logic [3:0] cnt;
  logic [2:0] nbyte;
  logic [7:0] sh;
  logic rw, quiet, ninth, hit;

  // ********
  // bus tracking
  // ********
  // the ninth pulse of a byte is the acknowledge slot
  assign ninth = (cnt == 4'h8);
  assign hit = (sh[7:1] == {`SRP_FIXED_ADDR, addr_select_pins_i});
  // quiet marks spans where the device has no business on the line
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cnt <= 4'h0;
      nbyte <= 3'h0;
      sh <= 8'h00;
      rw <= 1'b0;
      quiet <= 1'b1;
    end else if (scl && $past(scl) && $fell(sda)) begin
      cnt <= 4'h0;
      nbyte <= 3'h0;
      quiet <= 1'b0;
    end else if (scl && $past(scl) && $rose(sda)) begin
      quiet <= 1'b1;
    end else if ($rose(scl)) begin
      cnt <= ninth ? 4'h0 : cnt + 4'h1;
      nbyte <= ninth ? nbyte + 3'h1 : nbyte;
      sh <= ninth ? sh : {sh[6:0], sda};
      if (ninth && nbyte == 3'h0) begin
        rw <= sh[0];
        quiet <= quiet || !hit;
      end
      // refused index or master nack in a read ends the device's part
      if (ninth && ((nbyte == 3'h1 && !rw && sh > `SRP_REG_TOP) ||
          (nbyte != 3'h0 && rw && sda))) begin
        quiet <= 1'b1;
      end
    end
  end

  // ********
  // properties
  // ********
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_ninth;
    $rose(scl) && ninth && !quiet;
  endsequence
  sequence s_off8;
    (!dev_sda_oe)[*8];
  endsequence
  AST_SDA_MOVES_LOW: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data moved while clock high");
  AST_HIGH_STABLE: assert property ($rose(scl) |-> $stable(dev_sda_oe)[*3])
    else $error("device data unstable in clock high");
  AST_DRIVE_HOLDS: assert property ($rose(dev_sda_oe) |-> dev_sda_oe[*8])
    else $error("device low level too short");
  AST_ADDR_ACK: assert property (s_ninth ##0 (nbyte == 3'h0) |-> dev_sda_oe == hit)
    else $error("address acknowledge wrong");
  AST_INDEX_ACK: assert property (s_ninth ##0 (nbyte == 3'h1 && !rw) |->
    dev_sda_oe == (sh <= `SRP_REG_TOP))
    else $error("index acknowledge wrong");
  AST_DATA_ACK: assert property (s_ninth ##0 (nbyte > 3'h1 && !rw) |-> dev_sda_oe)
    else $error("write data not acknowledged");
  AST_READ_END: assert property (s_ninth ##0 (nbyte != 3'h0 && rw && sda) |-> ##1 s_off8)
    else $error("device kept driving after master nack");
  AST_IDLE_OFF: assert property (quiet |-> !dev_sda_oe)
    else $error("device drove line while idle");
endmodule

//--- tb/tb_top.sv
// self-checking bench: host end drives the device end over the link
`timescale 1ns/1ps
`include "srp_map.svh"
module tb_top;
  logic clock_i, reset_n_i, pix_valid_i, out_b_oe_o, fmt_422_o;
  logic [1:0] addr_select_pins_i;
  logic [7:0] pix_r_i, pix_g_i, pix_b_i, out_r_o, out_g_o, out_b_o, test_b_o, fmt_test_o;
  logic cmd_valid_i, cmd_read_i, busy_o, done_o, nack_o;
  logic [6:0] cmd_dev_addr_i, dv;
  logic [7:0] cmd_index_i, ix;
  logic [1:0] cmd_count_i, cn;
  logic [31:0] cmd_wdata_i, rdata_o;
  logic [7:0] ref_regs [0:`SRP_NUM_REGS-1];
  integer seed;
  int err_total, cmp_count, k;

  srp_if u_srp_if ();
  srp_dev u_srp_dev (.clock_i, .reset_n_i, .bus(u_srp_if), .addr_select_pins_i, .pix_valid_i,
    .pix_r_i, .pix_g_i, .pix_b_i, .out_r_o, .out_g_o, .out_b_o, .out_b_oe_o, .fmt_422_o,
    .test_b_o, .fmt_test_o);
  srp_host #(.QTR_CYC(2)) u_srp_host (.clock_i, .reset_n_i, .bus(u_srp_if), .cmd_valid_i,
    .cmd_read_i, .cmd_dev_addr_i, .cmd_index_i, .cmd_count_i, .cmd_wdata_i, .busy_o, .done_o,
    .nack_o, .rdata_o);
  srp_link_properties u_srp_link_properties (.clock_i, .reset_n_i, .scl(u_srp_if.scl),
    .sda(u_srp_if.sda), .dev_sda_oe(u_srp_if.dev_sda_oe), .addr_select_pins_i);

  // ********
  // helpers
  // ********
  // 100 ns clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    cmp_count++;
    if (sn !== ex) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, ex, sn);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // pointer stops at the top register
  function automatic logic [7:0] nxt(input logic [7:0] p);
    return (p < `SRP_REG_TOP) ? p + 8'h1 : p;
  endfunction

  // one host command; the model is updated or compared byte by byte
  task automatic xfer(input logic rd, input logic [6:0] da, input logic [7:0] ia,
    input logic [1:0] ca, input logic [31:0] wd, input logic nk);
    int n;
    logic [7:0] p;
    tick();
    cmd_read_i = rd;
    cmd_dev_addr_i = da;
    cmd_index_i = ia;
    cmd_count_i = ca;
    cmd_wdata_i = wd;
    cmd_valid_i = 1'b1;
    tick();
    cmd_valid_i = 1'b0;
    chk("busy", 1'b1, busy_o);
    for (n = 0; n < 4000 && done_o !== 1'b1; n++) tick();
    if (n >= 4000) begin
      err_total++;
      print_verdict();
    end
    chk("busy", 1'b0, busy_o);
    chk("nack", nk, nack_o);
    p = ia;
    for (n = 0; n <= ca && !nk; n++) begin
      if (rd) chk("rdata", ref_regs[p], rdata_o[8*n +: 8]);
      else ref_regs[p] = wd[8*n +: 8];
      p = nxt(p);
    end
  endtask

  // md: 0 full colour, 1 chroma U slot, 2 chroma V slot
  task automatic pix(input logic [1:0] md);
    pix_r_i = 8'($random(seed));
    pix_g_i = 8'($random(seed));
    pix_b_i = 8'($random(seed));
    pix_valid_i = 1'b1;
    tick();
    pix_valid_i = 1'b0;
    chk("green", pix_g_i, out_g_o);
    chk("red", (md == 2'h1) ? pix_b_i : pix_r_i, out_r_o);
    chk("blue_oe", md == 2'h0, out_b_oe_o);
    if (md == 2'h0) chk("blue", pix_b_i, out_b_o);
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    seed = 32'h61f2;
    addr_select_pins_i = 2'($random(seed));
    {reset_n_i, pix_valid_i, pix_r_i, pix_g_i, pix_b_i} = '0;
    {cmd_valid_i, cmd_read_i, cmd_dev_addr_i, cmd_index_i, cmd_count_i, cmd_wdata_i} = '0;
    err_total = 0;
    cmp_count = 0;
    for (k = 0; k < `SRP_NUM_REGS; k++) ref_regs[k] = 8'h00;
    repeat (10) @(posedge clock_i);
    #1;
    reset_n_i = 1'b1;
    // let the device synchronisers see the real pin levels
    repeat (3) tick();
    dv = {`SRP_FIXED_ADDR, addr_select_pins_i};
    chk("fmt_422", 1'b0, fmt_422_o);
    pix(2'h0);
    xfer(1'b1, dv, 8'h1a, 2'h3, 32'h0, 1'b0);
    xfer(1'b0, dv, 8'h1a, 2'h3, 32'($random(seed)), 1'b0);
    chk("test_b", ref_regs[27], test_b_o);
    chk("fmt_test", ref_regs[28], fmt_test_o);
    chk("fmt_422", ref_regs[28][1], fmt_422_o);
    xfer(1'b0, dv, 8'h1c, 2'h3, 32'($random(seed)), 1'b0);
    xfer(1'b1, dv, 8'h1c, 2'h1, 32'h0, 1'b0);
    for (k = 0; k < 8; k++) begin
      ix = 8'($unsigned($random(seed)) % `SRP_NUM_REGS);
      cn = 2'($random(seed));
      xfer(1'b0, dv, ix, cn, 32'($random(seed)), 1'b0);
      xfer(1'b1, dv, ix, cn, 32'h0, 1'b0);
    end
    // the other three strap addresses and a wrong fixed part are ignored
    for (k = 1; k < 4; k++) begin
      xfer(k[0], {`SRP_FIXED_ADDR, addr_select_pins_i ^ 2'(k)}, 8'h0, 2'h0, 32'h0, 1'b1);
    end
    xfer(1'b0, dv ^ 7'h40, 8'h00, 2'h0, 32'h0, 1'b1);
    xfer(1'b0, dv, 8'h1e, 2'h1, 32'h5a5a, 1'b1);
    xfer(1'b0, dv, 8'hff, 2'h0, 32'h5a, 1'b1);
    xfer(1'b1, dv, 8'h00, 2'h3, 32'h0, 1'b0);
    xfer(1'b1, dv, 8'h1a, 2'h3, 32'h0, 1'b0);
    xfer(1'b0, dv, 8'h1c, 2'h0, 32'h0, 1'b0);
    pix(2'h0);
    xfer(1'b0, dv, 8'h1b, 2'h1, 32'h6f10, 1'b0);
    pix(2'h1);
    pix(2'h2);
    pix(2'h1);
    print_verdict();
  end
endmodule
